// ===== verilog/mpss_top.sv
// Purpose: tracks mode and privilege, selects the active stack pointer
// Assumes: exception sequencing lives elsewhere and drives entry/return
// Notes: all outputs registered; stack pointers held here as a bank
`timescale 1ns/1ns
`default_nettype none
module mpss_top import mpss_pkg::*; #(
	parameter bit HAS_UNPRIV_EXT = 1'b1,
	parameter bit HAS_TIMER = 1'b1,
	parameter bit HAS_DEBUG = 1'b1,
	parameter int EXC_W = 6
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic exc_entry_i,
	input wire logic [EXC_W-1:0] exc_num_i,
	input wire logic exc_return_i,
	input wire logic ret_to_thread_i,
	input wire logic ret_use_process_i,
	input wire logic ctrl_wr_i,
	input wire logic ctrl_unpriv_i,
	input wire logic ctrl_spsel_i,
	input wire logic sp_wr_i,
	input wire logic sp_wr_process_i,
	input wire logic sp_wr_active_i,
	input wire logic [31:0] sp_wdata_i,
	input wire logic vtor_wr_i,
	input wire logic [31:0] vtor_wdata_i,
	input wire logic [31:0] addr_i,
	output mpss_state_s state_o,
	output logic thread_unprivileged_bit_o,
	output logic ret_illegal_o,
	output logic [31:0] active_sp_o,
	output logic [31:0] main_sp_o,
	output logic [31:0] process_sp_o,
	output mpss_decode_s dec_o,
	output logic vec_fetch_o,
	output logic [31:0] vec_addr_o
);
	mpss_mode_e mode;
	logic thread_unprivileged_bit;
	logic spsel;
	logic [31:0] sp_bank [2];
	logic [31:0] vtor;
	logic ret_ok;
	mpss_mode_e next_mode;
	logic next_spsel;
	logic sel_process;
	logic next_priv;

	// return is honoured only while in Handler
	assign ret_ok = exc_return_i && mode == MPSS_HANDLER; // see R7

	always_comb begin
		next_mode = mode;
		next_spsel = spsel;
		if (exc_entry_i) begin
			next_mode = MPSS_HANDLER; // see R7
		end else if (ret_ok) begin
			// nested return stays in Handler
			next_mode = ret_to_thread_i ? MPSS_THREAD : MPSS_HANDLER; // see R6 see R13
			if (ret_to_thread_i) begin
				next_spsel = ret_use_process_i; // see R12
			end
		end else if (ctrl_wr_i && mode == MPSS_THREAD) begin
			next_spsel = ctrl_spsel_i; // see R12
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			mode <= MPSS_THREAD; // see R6
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			spsel <= 1'b0;
		end else begin
			spsel <= next_spsel;
		end
	end

	// only privileged code may change the control bit
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			thread_unprivileged_bit <= 1'b0; // see R14
		end else if (ctrl_wr_i && state_o.privileged && HAS_UNPRIV_EXT) begin
			thread_unprivileged_bit <= ctrl_unpriv_i; // see R9
		end
	end

	always_comb begin
		// main stack forced in Handler regardless of select bit
		sel_process = next_mode == MPSS_THREAD && next_spsel; // see R11 see R12
		next_priv = !HAS_UNPRIV_EXT || next_mode == MPSS_HANDLER
			|| !thread_unprivileged_bit; // see R8 see R10
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			sp_bank[0] <= '0;
			sp_bank[1] <= '0;
		end else if (sp_wr_i) begin
			// word aligned; low bits dropped
			if (sp_wr_active_i) begin
				sp_bank[sel_process] <= {sp_wdata_i[31:2], 2'b00}; // see R11
			end else begin
				sp_bank[sp_wr_process_i] <= {sp_wdata_i[31:2], 2'b00};
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			vtor <= VTOR_RESET;
		end else if (vtor_wr_i) begin
			vtor <= {vtor_wdata_i[31:7], 7'h00};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			state_o <= '{privileged: 1'b1, handler: 1'b0, use_process_sp: 1'b0};
			thread_unprivileged_bit_o <= 1'b0;
			ret_illegal_o <= 1'b0;
		end else begin
			state_o.privileged <= next_priv; // see R9 see R10
			state_o.handler <= next_mode == MPSS_HANDLER;
			state_o.use_process_sp <= sel_process;
			// reads as zero when the extension is absent
			thread_unprivileged_bit_o <= HAS_UNPRIV_EXT && thread_unprivileged_bit; // see R14
			ret_illegal_o <= exc_return_i && mode != MPSS_HANDLER; // see R7
		end
	end

	// bank shown as it stood before this edge's write: a write is seen one cycle later
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			active_sp_o <= '0;
			main_sp_o <= '0;
			process_sp_o <= '0;
		end else begin
			active_sp_o <= sp_bank[sel_process];
			main_sp_o <= sp_bank[0];
			process_sp_o <= sp_bank[1];
		end
	end

	mpss_addr_dec #(
		.HAS_TIMER(HAS_TIMER),
		.HAS_DEBUG(HAS_DEBUG),
		.HAS_PROT(HAS_UNPRIV_EXT)
	) u_dec (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.addr_i(addr_i),
		.dec_o(dec_o)
	);

	mpss_vec_addr #(
		.EXC_W(EXC_W)
	) u_vec (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.req_i(exc_entry_i),
		.exc_num_i(exc_num_i),
		.base_i(vtor),
		.fetch_o(vec_fetch_o),
		.fetch_addr_o(vec_addr_o)
	);
endmodule
`default_nettype wire

// ===== verilog/mpss_pkg.sv
// Purpose: constants and carriers for the mode, privilege and stack select block
// Assumes: 32-bit physical addresses, single core clock
// Notes on behaviour
// R1: 0xE0000000..0xFFFFFFFF decodes as system space
// R2: lowest 1MB private; above 0xE0100000 implementation space
// R3: 0xE000E000..0xE000EFFF decodes as system control space
// R4: control space holds id, control, handlers, interrupt controller
// R5: handler entry fetched from vector table pointers
// R6: reset release and exception return enter Thread; here a nested return (ret_to_thread_i low) stays in Handler
// R7: exception entry gives Handler; return only from Handler
// R8: without extension all execution is privileged
// R9: Handler always privileged; Thread follows control bit
// R10: privileged when Handler or control bit zero
// R11: two banked stack pointers, exactly one active
// R12: Handler uses main stack; Thread selects either
// R13: return goes to Thread if Thread was interrupted
// R14: control bit resets zero; reads zero without extension
package mpss_pkg;
	localparam logic [31:0] SYS_BASE = 32'hE000_0000;
	localparam logic [31:0] PPR_LIMIT = 32'hE00F_FFFF;
	localparam logic [31:0] IMPL_BASE = 32'hE010_0000;
	localparam logic [31:0] CTL_SPACE_BASE = 32'hE000_E000;
	localparam logic [31:0] CTL_SPACE_LIMIT = 32'hE000_EFFF;
	localparam int CTL_IDX_LSB = 8;
	localparam int CTL_IDX_MSB = 11;
	localparam logic [3:0] CTL_SUB_ID = 4'hD;
	localparam logic [3:0] CTL_SUB_IRQ_LO = 4'h1;
	localparam logic [3:0] CTL_SUB_IRQ_HI = 4'h4;
	localparam logic [3:0] CTL_SUB_TIMER = 4'h0;
	localparam logic [3:0] CTL_SUB_PROT = 4'h9;
	localparam logic [3:0] CTL_SUB_DEBUG = 4'hD;
	localparam int NUM_EXT_IRQ = 32;
	localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
	localparam int VEC_SHIFT = 2;
	localparam logic [31:0] VEC_ALIGN_MASK = 32'hFFFF_FFFE;

	typedef enum logic [1:0] {
		MPSS_THREAD = 2'b01,
		MPSS_HANDLER = 2'b10
	} mpss_mode_e;

	typedef struct packed {
		logic system_space;
		logic private_peripheral_region;
		logic impl_space;
		logic system_control_space;
		logic ctl_id;
		logic ctl_general;
		logic ctl_nested_irq_controller;
		logic ctl_timer;
		logic ctl_region_protection_unit;
		logic ctl_debug;
	} mpss_decode_s;

	typedef struct packed {
		logic privileged;
		logic handler;
		logic use_process_sp;
	} mpss_state_s;
endpackage

// ===== verilog/mpss_addr_dec.sv
// Purpose: registered decode of the fixed system address regions
// Assumes: address from core logic on the same clock
// Notes: one cycle latency; optional sub-blocks gated by parameters
`timescale 1ns/1ns
`default_nettype none
module mpss_addr_dec import mpss_pkg::*; #(
	parameter bit HAS_TIMER = 1'b1,
	parameter bit HAS_DEBUG = 1'b1,
	parameter bit HAS_PROT = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [31:0] addr_i,
	output mpss_decode_s dec_o
);
	mpss_decode_s next_dec;
	logic [3:0] sub;

	always_comb begin
		sub = addr_i[CTL_IDX_MSB:CTL_IDX_LSB];
		next_dec = '0;
		next_dec.system_space = addr_i >= SYS_BASE; // see R1
		next_dec.private_peripheral_region = next_dec.system_space && addr_i <= PPR_LIMIT; // see R2
		next_dec.impl_space = addr_i >= IMPL_BASE; // see R2
		next_dec.system_control_space = addr_i >= CTL_SPACE_BASE
			&& addr_i <= CTL_SPACE_LIMIT; // see R3
		if (next_dec.system_control_space) begin
			// debug shares the id page; id wins below its upper half
			next_dec.ctl_id = sub == CTL_SUB_ID && !addr_i[7]; // see R4
			next_dec.ctl_debug = HAS_DEBUG && sub == CTL_SUB_DEBUG && addr_i[7]; // see R4
			next_dec.ctl_nested_irq_controller = sub >= CTL_SUB_IRQ_LO
				&& sub <= CTL_SUB_IRQ_HI; // see R4
			next_dec.ctl_timer = HAS_TIMER && sub == CTL_SUB_TIMER && addr_i[4]; // see R4
			next_dec.ctl_region_protection_unit = HAS_PROT && sub == CTL_SUB_PROT; // see R4
			next_dec.ctl_general = !(next_dec.ctl_id || next_dec.ctl_debug
				|| next_dec.ctl_nested_irq_controller || next_dec.ctl_timer
				|| next_dec.ctl_region_protection_unit); // see R4
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			dec_o <= '0;
		end else begin
			dec_o <= next_dec;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/mpss_vec_addr.sv
// Purpose: forms the vector table slot address for an exception number
// Assumes: table base word aligned
// Notes: registered, one cycle after the request
`timescale 1ns/1ns
`default_nettype none
module mpss_vec_addr import mpss_pkg::*; #(
	parameter int EXC_W = 6
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic req_i,
	input wire logic [EXC_W-1:0] exc_num_i,
	input wire logic [31:0] base_i,
	output logic fetch_o,
	output logic [31:0] fetch_addr_o
);
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			fetch_o <= 1'b0;
			fetch_addr_o <= VTOR_RESET;
		end else begin
			fetch_o <= req_i; // see R5
			if (req_i) begin
				fetch_addr_o <= base_i + (32'(exc_num_i) << VEC_SHIFT); // see R5
			end
		end
	end
endmodule
`default_nettype wire

// ===== verification/mpss_top_chk.sv
// Purpose: mode, privilege, stack and decode checks on mpss_top
// Assumes: sync active low reset
// Notes: decode checks skip the edge right after reset
`timescale 1ns/1ns
`default_nettype none
module mpss_top_chk import mpss_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic exc_entry_i,
	input wire logic exc_return_i,
	input wire logic ret_to_thread_i,
	input wire logic ret_use_process_i,
	input wire logic [31:0] addr_i,
	input wire mpss_state_s state_o,
	input wire logic thread_unprivileged_bit_o,
	input wire logic ret_illegal_o,
	input wire logic [31:0] active_sp_o,
	input wire logic [31:0] main_sp_o,
	input wire logic [31:0] process_sp_o,
	input wire mpss_decode_s dec_o,
	input wire logic vec_fetch_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	a_sys_space: assert property ($past(rstn_i) |->
		dec_o.system_space == ($past(addr_i) >= SYS_BASE)) else $error("bad system decode");
	a_ppr_region: assert property ($past(rstn_i) |->
		dec_o.private_peripheral_region == ($past(addr_i) >= SYS_BASE &&
		$past(addr_i) <= PPR_LIMIT)) else $error("bad private decode");
	a_impl_space: assert property ($past(rstn_i) |->
		dec_o.impl_space == ($past(addr_i) >= IMPL_BASE)) else $error("bad impl decode");
	a_scs_window: assert property ($past(rstn_i) |->
		dec_o.system_control_space == ($past(addr_i) >= CTL_SPACE_BASE &&
		$past(addr_i) <= CTL_SPACE_LIMIT)) else $error("bad control space decode");
	a_priv_query: assert property (state_o.privileged ==
		(state_o.handler || !thread_unprivileged_bit_o)) else $error("bad privilege");
	a_handler_main: assert property (state_o.handler |->
		!state_o.use_process_sp) else $error("handler on process stack");
	a_active_sp: assert property (active_sp_o ==
		(state_o.use_process_sp ? process_sp_o : main_sp_o)) else $error("bad active sp");
	a_entry_mode: assert property (exc_entry_i |=> state_o.handler &&
		!state_o.use_process_sp && vec_fetch_o) else $error("entry not handler");
	a_ret_refused: assert property (exc_return_i && !exc_entry_i &&
		!state_o.handler |=> ret_illegal_o) else $error("return not refused");
	a_ret_thread: assert property (exc_return_i && !exc_entry_i &&
		state_o.handler && ret_to_thread_i |=> !state_o.handler &&
		state_o.use_process_sp == $past(ret_use_process_i)) else $error("bad return");
endmodule
bind mpss_top mpss_top_chk chk_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.exc_entry_i(exc_entry_i), .exc_return_i(exc_return_i), .ret_to_thread_i(ret_to_thread_i),
	.ret_use_process_i(ret_use_process_i), .addr_i(addr_i), .state_o(state_o),
	.thread_unprivileged_bit_o(thread_unprivileged_bit_o), .ret_illegal_o(ret_illegal_o),
	.active_sp_o(active_sp_o), .main_sp_o(main_sp_o), .process_sp_o(process_sp_o),
	.dec_o(dec_o), .vec_fetch_o(vec_fetch_o));
`default_nettype wire

// ===== verification/mpss_top_tb_top.sv
// Purpose: self-checking bench for mpss_top
// Assumes: inputs change 1 ns after the rising edge
// Notes: reset checks first, then decode table, then mode and stack sequences, then a second reset
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module mpss_top_tb_top import mpss_pkg::*; ;
	logic ref_clk_i = 0, rstn_i = 0, ent = 0, ret = 0, to_thr = 0, ret_ps = 0;
	logic cw = 0, cu = 0, cs = 0, spw = 0, vw = 0, spa = 1, spp = 0;
	logic [5:0] num = 6'h00;
	logic [31:0] spd = 32'h0, vd = 32'h0, addr = 32'h0;
	mpss_state_s st, st2;
	mpss_decode_s dec;
	logic tub, ill, vf, tub2;
	logic [31:0] asp, msp, psp, va;
	int fails = 0, num_checks = 0;
	// rows: address, then the whole decode struct, system space in the top bit
	logic [41:0] rows [14] = '{{32'hE000_0000, 10'h300}, {32'hDFFF_FFFF, 10'h000},
		{32'hE000_E000, 10'h350}, {32'hE000_EFFF, 10'h350}, {32'hE000_DFFF, 10'h300},
		{32'hE000_F000, 10'h300}, {32'hE00F_FFFF, 10'h300}, {32'hE010_0000, 10'h280},
		{32'hFFFF_FFFF, 10'h280}, {32'hE000_E010, 10'h344}, {32'hE000_E100, 10'h348},
		{32'hE000_E900, 10'h342}, {32'hE000_ED00, 10'h360}, {32'hE000_ED80, 10'h341}};
	mpss_top dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .exc_entry_i(ent),
		.exc_num_i(num), .exc_return_i(ret), .ret_to_thread_i(to_thr),
		.ret_use_process_i(ret_ps), .ctrl_wr_i(cw), .ctrl_unpriv_i(cu),
		.ctrl_spsel_i(cs), .sp_wr_i(spw), .sp_wr_process_i(spp),
		.sp_wr_active_i(spa), .sp_wdata_i(spd), .vtor_wr_i(vw),
		.vtor_wdata_i(vd), .addr_i(addr), .state_o(st),
		.thread_unprivileged_bit_o(tub), .ret_illegal_o(ill), .active_sp_o(asp),
		.main_sp_o(msp), .process_sp_o(psp), .dec_o(dec), .vec_fetch_o(vf),
		.vec_addr_o(va));
	// same stimulus, extension absent: always privileged, bit reads zero
	mpss_top #(.HAS_UNPRIV_EXT(1'b0)) dut_noext_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.exc_entry_i(ent), .exc_num_i(num), .exc_return_i(ret), .ret_to_thread_i(to_thr),
		.ret_use_process_i(ret_ps), .ctrl_wr_i(cw), .ctrl_unpriv_i(cu), .ctrl_spsel_i(cs),
		.sp_wr_i(spw), .sp_wr_process_i(spp), .sp_wr_active_i(spa), .sp_wdata_i(spd),
		.vtor_wr_i(vw), .vtor_wdata_i(vd), .addr_i(addr), .state_o(st2),
		.thread_unprivileged_bit_o(tub2), .ret_illegal_o(), .active_sp_o(), .main_sp_o(),
		.process_sp_o(), .dec_o(), .vec_fetch_o(), .vec_addr_o());
	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	task automatic step();
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// generous: the sequence needs about 28 cycles
	initial begin
		#1000;
		fails++;
		report_and_stop();
	end
	initial begin
		repeat (5) step();
		`CHK("reset state", 3'b100, st)
		`CHK("reset bit", 1'b0, tub)
		$display("reset checks done");
		rstn_i = 1;
		foreach (rows[i]) begin
			addr = rows[i][41:10];
			step();
			`CHK("decode", rows[i][9:0], dec)
		end
		$display("decode table done");
		vd = 32'h0000_1000;
		vw = 1;
		cw = 1;
		cu = 1;
		cs = 1;
		step();
		vw = 0;
		cw = 0;
		spd = 32'h1234_5678;
		spw = 1;
		step();
		spw = 0;
		`CHK("thread state", 3'b001, st)
		`CHK("ext absent priv", 3'b101, st2)
		`CHK("ext absent bit", 1'b0, tub2)
		// stack outputs show a write one cycle later
		step();
		`CHK("active sp", 32'h1234_5678, asp)
		`CHK("process sp", 32'h1234_5678, psp)
		`CHK("main sp untouched", 32'h0, msp)
		num = 6'h05;
		ent = 1;
		step();
		ent = 0;
		`CHK("entry state", 3'b110, st)
		`CHK("vec fetch", 1'b1, vf)
		`CHK("vec addr", 32'h0000_1014, va)
		`CHK("handler sp", 32'h0, asp)
		// explicit main stack write; low bits must drop
		spd = 32'h0000_0ABF;
		spa = 0;
		spw = 1;
		step();
		spw = 0;
		spa = 1;
		`CHK("handler kept", 3'b110, st)
		// return held for two edges: first lands in Thread, second is refused
		ret = 1;
		to_thr = 1;
		ret_ps = 1;
		step();
		`CHK("return state", 3'b001, st)
		`CHK("main sp written", 32'h0000_0ABC, msp)
		`CHK("thread process sp", 32'h1234_5678, asp)
		step();
		ret = 0;
		`CHK("refused return", 1'b1, ill)
		`CHK("still thread", 3'b001, st)
		cw = 1;
		cu = 0;
		step();
		cw = 0;
		`CHK("unpriv clear ignored", 1'b1, tub)
		$display("mode sequence done");
		rstn_i = 0;
		step();
		`CHK("second reset", 3'b100, st)
		`CHK("second reset bit", 1'b0, tub)
		$display("second reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
